// ### sra_map.svh
// Purpose : Constants for the status register command interpreter
// Assumes : Serial link in mode 0, commands and data most significant first
// Notes   : Function
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH

// ****************************************************************
// Commands
// ****************************************************************
`define SRA_CMD_RD_INDIRECT 8'h65
`define SRA_CMD_WR_INDIRECT 8'h71
`define SRA_CMD_WR_ONE      8'h01
`define SRA_CMD_WR_TWO      8'h31
`define SRA_CMD_WR_THREE    8'h11
`define SRA_CMD_WR_ENABLE   8'h06
`define SRA_CMD_WR_DISABLE  8'h04
`define SRA_CMD_VOL_ENABLE  8'h50

// ****************************************************************
// Register map
// ****************************************************************
`define SRA_OFF_STATUS_REG_ONE   8'h01
`define SRA_OFF_STATUS_REG_TWO   8'h02
`define SRA_OFF_STATUS_REG_THREE 8'h03
`define SRA_OFF_STATUS_REG_FOUR  8'h04
`define SRA_OFF_STATUS_REG_FIVE  8'h05
`define SRA_OFF_STATUS_REG_SIX   8'h06
`define SRA_REG_MIN              3
`define SRA_REG_MAX              6
`define SRA_STATUS_RESET         8'h00
`define SRA_UNDEF_BYTE           8'h00
`define SRA_WEL_POS              1

// ****************************************************************
// Frame layout
// ****************************************************************
`define SRA_LAST_BIT   3'h7
`define SRA_BYTE_SAT   3'h7
`define SRA_DATA_BYTE  3'h3
`define SRA_DIRECT_LEN 3'h2
`define SRA_LEGACY_LEN 3'h3
`define SRA_INDIR_LEN  3'h3

`endif

// ### sra_pkg.sv
// Purpose : Types for the status register command interpreter
// Assumes : Constants come from sra_map.svh
// Notes   : Types only
package sra_pkg;
    typedef logic [7:0] sra_byte_t;
    typedef logic [2:0] sra_count_t;
    typedef logic [2:0] sra_idx_t;
endpackage : sra_pkg

// ### sra_status_access.sv
// Purpose : Status register read and write commands behind the serial link
// Assumes : Link mode 0; chip select high for at least 4 ref_clk periods
// Notes   : Link logic runs on spiClk; registers live on ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "sra_map.svh"

module sra_status_access #(
    parameter int REG_COUNT = `SRA_REG_MAX
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic spiClk,
    input  wire logic spiCsN,
    input  wire logic spiSi,
    output var  logic spiSoData,
    output var  logic spiSoEnN
);
    import sra_pkg::*;

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    generate
        if (REG_COUNT < `SRA_REG_MIN || REG_COUNT > `SRA_REG_MAX) begin : g_bad
            $error("REG_COUNT out of range");
        end
    endgenerate

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic regHit(input sra_byte_t a);
        regHit = (a >= `SRA_OFF_STATUS_REG_ONE) && (a <= 8'(REG_COUNT));
    endfunction : regHit

    function automatic sra_idx_t regIdx(input sra_byte_t a);
        regIdx = 3'(a - `SRA_OFF_STATUS_REG_ONE);
    endfunction : regIdx

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rstPipe_reg;
    logic [1:0] rstPipe_next;
    logic       rstN;

    always_comb begin
        rstPipe_next = {rstPipe_reg[0], 1'b1};
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe_reg <= 2'h0;
        end else begin
            rstPipe_reg <= rstPipe_next;
        end
    end

    assign rstN = rstPipe_reg[1];

    // ****************************************************************
    // Link side: frame marker
    // ****************************************************************
    // Link clock only runs inside frames, so the frame is ended by
    // chip select itself rather than by a final edge.
    logic frameRst;
    logic inFrame_reg;
    logic inFrame_next;

    assign frameRst = spiCsN | ~rstN;

    always_comb begin
        inFrame_next = 1'b1;
    end

    always_ff @(posedge spiClk or posedge frameRst) begin
        if (frameRst) begin
            inFrame_reg <= 1'b0;
        end else begin
            inFrame_reg <= inFrame_next;
        end
    end

    // ****************************************************************
    // Link side: input shifter
    // ****************************************************************
    // Counters keep the last frame after chip select rises, so the
    // ref_clk side can read them while the link clock stands still.
    sra_count_t bitCnt_reg;
    sra_count_t bitCnt_next;
    sra_count_t byteCnt_reg;
    sra_count_t byteCnt_next;
    sra_count_t bitCur;
    sra_count_t byteCur;
    logic [6:0] shift_reg;
    logic [6:0] shift_next;
    sra_byte_t  rxByte;
    sra_byte_t  cmd_reg;
    sra_byte_t  cmd_next;
    sra_byte_t  byte1_reg;
    sra_byte_t  byte1_next;
    sra_byte_t  byte2_reg;
    sra_byte_t  byte2_next;
    sra_byte_t  rdAddr_reg;
    sra_byte_t  rdAddr_next;
    logic       frameTog_reg;
    logic       frameTog_next;

    always_comb begin
        bitCur        = inFrame_reg ? bitCnt_reg : 3'h0;
        byteCur       = inFrame_reg ? byteCnt_reg : 3'h0;
        rxByte        = {shift_reg, spiSi};
        bitCnt_next   = 3'(bitCur + 3'h1);
        byteCnt_next  = byteCur;
        shift_next    = rxByte[6:0];
        cmd_next      = cmd_reg;
        byte1_next    = byte1_reg;
        byte2_next    = byte2_reg;
        rdAddr_next   = rdAddr_reg;
        frameTog_next = inFrame_reg ? frameTog_reg : ~frameTog_reg;
        if (bitCur == `SRA_LAST_BIT) begin
            if (byteCur != `SRA_BYTE_SAT) begin
                byteCnt_next = 3'(byteCur + 3'h1);
            end
            case (byteCur)
                3'h0: begin
                    cmd_next = rxByte;
                end
                3'h1: begin
                    byte1_next  = rxByte;
                    rdAddr_next = rxByte;
                end
                3'h2: begin
                    byte2_next = rxByte;
                end
                default: begin
                end
            endcase
            if (byteCur >= `SRA_DATA_BYTE &&
                cmd_reg == `SRA_CMD_RD_INDIRECT) begin
                // 8-bit address wraps from the top back to zero
                rdAddr_next = 8'(rdAddr_reg + 8'h01);
            end
        end
    end

    always_ff @(posedge spiClk or negedge rstN) begin
        if (!rstN) begin
            bitCnt_reg   <= 3'h0;
            byteCnt_reg  <= 3'h0;
            shift_reg    <= 7'h00;
            cmd_reg      <= 8'h00;
            byte1_reg    <= 8'h00;
            byte2_reg    <= 8'h00;
            rdAddr_reg   <= 8'h00;
            frameTog_reg <= 1'b0;
        end else begin
            bitCnt_reg   <= bitCnt_next;
            byteCnt_reg  <= byteCnt_next;
            shift_reg    <= shift_next;
            cmd_reg      <= cmd_next;
            byte1_reg    <= byte1_next;
            byte2_reg    <= byte2_next;
            rdAddr_reg   <= rdAddr_next;
            frameTog_reg <= frameTog_next;
        end
    end

    // ****************************************************************
    // Link side: output shifter
    // ****************************************************************
    // Register values only change between frames, so the selected
    // byte is stable when the falling edge captures it.
    sra_byte_t statView [REG_COUNT];
    sra_byte_t txSel;
    sra_byte_t txShift_reg;
    sra_byte_t txShift_next;
    logic      txEnN_reg;
    logic      txEnN_next;
    logic      txLoad;

    always_comb begin
        txSel = regHit(rdAddr_reg) ? statView[regIdx(rdAddr_reg)]
                                   : `SRA_UNDEF_BYTE;
        txLoad = inFrame_reg && (cmd_reg == `SRA_CMD_RD_INDIRECT) &&
                 (byteCnt_reg >= `SRA_DATA_BYTE) &&
                 (bitCnt_reg == 3'h0);
        txShift_next = txShift_reg;
        txEnN_next   = txEnN_reg;
        if (txLoad) begin
            txShift_next = txSel;
            txEnN_next   = 1'b0;
        end else if (!txEnN_reg) begin
            txShift_next = {txShift_reg[6:0], 1'b0};
        end
    end

    always_ff @(negedge spiClk or posedge frameRst) begin
        if (frameRst) begin
            txShift_reg <= 8'h00;
            txEnN_reg   <= 1'b1;
        end else begin
            txShift_reg <= txShift_next;
            txEnN_reg   <= txEnN_next;
        end
    end

    assign spiSoData = txShift_reg[7];
    assign spiSoEnN  = txEnN_reg;

    // ****************************************************************
    // Register side: crossing and commit
    // ****************************************************************
    logic [2:0] csPipe_reg;
    logic [2:0] csPipe_next;
    logic [2:0] togPipe_reg;
    logic [2:0] togPipe_next;
    logic       csHigh_reg;
    logic       csHigh_next;
    logic       togHeld_reg;
    logic       togHeld_next;
    logic       togSeen_reg;
    logic       togSeen_next;
    logic       wel_reg;
    logic       wel_next;
    logic       volEn_reg;
    logic       volEn_next;
    sra_byte_t  statReg_reg  [REG_COUNT];
    sra_byte_t  statReg_next [REG_COUNT];
    logic       commit;
    logic       aligned;
    logic       allowed;
    sra_idx_t   dirIdx;

    always_comb begin
        csPipe_next  = {csPipe_reg[1:0], spiCsN};
        togPipe_next = {togPipe_reg[1:0], frameTog_reg};
        csHigh_next  = csHigh_reg;
        togHeld_next = togHeld_reg;
        togSeen_next = togSeen_reg;
        statReg_next = statReg_reg;
        wel_next     = wel_reg;
        volEn_next   = volEn_reg;
        if (csPipe_reg[1] == csPipe_reg[2]) begin
            csHigh_next = csPipe_reg[2];
        end
        if (togPipe_reg[1] == togPipe_reg[2]) begin
            togHeld_next = togPipe_reg[2];
        end
        // Short frames may show chip select low for one sample only, so
        // a finished frame is told by its toggle, not a chip select edge
        commit  = csHigh_next && (togHeld_reg != togSeen_reg);
        aligned = (bitCnt_reg == 3'h0);
        allowed = wel_reg | volEn_reg;
        case (cmd_reg)
            `SRA_CMD_WR_TWO: begin
                dirIdx = regIdx(`SRA_OFF_STATUS_REG_TWO);
            end
            `SRA_CMD_WR_THREE: begin
                dirIdx = regIdx(`SRA_OFF_STATUS_REG_THREE);
            end
            default: begin
                dirIdx = regIdx(`SRA_OFF_STATUS_REG_ONE);
            end
        endcase
        if (commit) begin
            togSeen_next = togHeld_reg;
            case (cmd_reg)
                `SRA_CMD_WR_ENABLE: begin
                    if (aligned && byteCnt_reg == 3'h1) begin
                        wel_next = 1'b1;
                    end
                end
                `SRA_CMD_WR_DISABLE: begin
                    if (aligned && byteCnt_reg == 3'h1) begin
                        wel_next = 1'b0;
                    end
                end
                `SRA_CMD_VOL_ENABLE: begin
                    if (aligned && byteCnt_reg == 3'h1) begin
                        volEn_next = 1'b1;
                    end
                end
                `SRA_CMD_WR_ONE, `SRA_CMD_WR_TWO,
                `SRA_CMD_WR_THREE: begin
                    if (aligned && byteCnt_reg >= `SRA_DIRECT_LEN) begin
                        wel_next   = 1'b0;
                        volEn_next = 1'b0;
                        if (allowed &&
                            (byteCnt_reg == `SRA_DIRECT_LEN ||
                             (cmd_reg == `SRA_CMD_WR_ONE &&
                              byteCnt_reg == `SRA_LEGACY_LEN))) begin
                            statReg_next[dirIdx] = byte1_reg;
                            if (byteCnt_reg == `SRA_LEGACY_LEN) begin
                                statReg_next[regIdx(
                                    `SRA_OFF_STATUS_REG_TWO)] =
                                    byte2_reg;
                            end
                        end
                    end
                end
                `SRA_CMD_WR_INDIRECT: begin
                    if (aligned && byteCnt_reg >= `SRA_INDIR_LEN) begin
                        wel_next   = 1'b0;
                        volEn_next = 1'b0;
                        if (allowed && regHit(byte1_reg) &&
                            byteCnt_reg == `SRA_INDIR_LEN) begin
                            statReg_next[regIdx(byte1_reg)] =
                                byte2_reg;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            csPipe_reg  <= 3'h7;
            togPipe_reg <= 3'h0;
            csHigh_reg  <= 1'b1;
            togHeld_reg <= 1'b0;
            togSeen_reg <= 1'b0;
            wel_reg     <= 1'b0;
            volEn_reg   <= 1'b0;
            for (int i = 0; i < REG_COUNT; i++) begin
                statReg_reg[i] <= `SRA_STATUS_RESET;
            end
        end else begin
            csPipe_reg   <= csPipe_next;
            togPipe_reg  <= togPipe_next;
            csHigh_reg   <= csHigh_next;
            togHeld_reg  <= togHeld_next;
            togSeen_reg  <= togSeen_next;
            wel_reg      <= wel_next;
            volEn_reg    <= volEn_next;
            statReg_reg  <= statReg_next;
        end
    end

    // ****************************************************************
    // Register view toward the link
    // ****************************************************************
    // The latch bit is owned here, so a written register 1 cannot
    // change it directly.
    always_comb begin
        statView = statReg_reg;
        statView[regIdx(`SRA_OFF_STATUS_REG_ONE)][`SRA_WEL_POS] = wel_reg;
    end

endmodule : sra_status_access
`default_nettype wire

// ### sra_link_monitor.sv
// Purpose : Link protocol checks for the status register block
// Assumes : Host runs the link in mode 0, chip select high between frames
// Notes   : Bound to sra_status_access below
`timescale 1ns/10ps
`default_nettype none
module sra_link_monitor #(
    parameter int REG_COUNT = 6
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiSi,
    input wire logic spiSoData,
    input wire logic spiSoEnN
);
    logic [15:0] bitCnt;
    logic [15:0] hdr;
    logic [1:0]  latchKnown;
    logic [7:0]  rdAddr;
    wire         isRead = (hdr[15:8] == 8'h65);
    assign rdAddr = hdr[7:0] + 8'(bitCnt[15:3] - 13'h0003);

    // ****************************************************************
    // Frame tracking
    // ****************************************************************
    always_ff @(posedge spiClk or posedge spiCsN) begin
        if (spiCsN) begin
            bitCnt <= '0;
            hdr    <= '0;
        end else begin
            bitCnt <= bitCnt + 16'h0001;
            if (bitCnt < 16'h0010) begin
                hdr <= {hdr[14:0], spiSi};
            end
        end
    end

    // Latch value is only trusted right after an enable, disable or reset
    always_ff @(posedge spiCsN or negedge reset_n) begin
        if (!reset_n) begin
            latchKnown <= 2'b10;
        end else if (bitCnt == 16'h0008 && hdr[7:0] == 8'h06) begin
            latchKnown <= 2'b11;
        end else if (bitCnt == 16'h0008 && hdr[7:0] == 8'h04) begin
            latchKnown <= 2'b10;
        end else begin
            latchKnown <= 2'b00;
        end
    end

    sequence sDummyEnd;
        !spiCsN && bitCnt == 16'h0017 && isRead;
    endsequence

    sequence sFirstData;
        !spiCsN && bitCnt == 16'h0018;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_QUIET_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        spiCsN |-> spiSoEnN) else $error("Output driven while deselected");
    AST_NO_EARLY_DRIVE: assert property (@(posedge spiClk) disable iff (!reset_n)
        !spiCsN && bitCnt < 16'h0018 |-> spiSoEnN)
        else $error("Output driven before clock 24");
    AST_DATA_START: assert property (@(posedge spiClk) disable iff (!reset_n)
        sDummyEnd ##1 sFirstData |-> !spiSoEnN)
        else $error("Read data not driven at clock 24");
    AST_READ_DRIVES: assert property (@(posedge spiClk) disable iff (!reset_n)
        !spiCsN && isRead && bitCnt >= 16'h0018 |-> !spiSoEnN)
        else $error("Read output dropped during frame");
    AST_WRITE_SILENT: assert property (@(posedge spiClk) disable iff (!reset_n)
        !spiCsN && !isRead && bitCnt >= 16'h0010 |-> spiSoEnN)
        else $error("Output driven outside a read");
    AST_UNDEF_ZERO: assert property (@(posedge spiClk) disable iff (!reset_n)
        !spiCsN && isRead && bitCnt >= 16'h0018 &&
        (rdAddr == 8'h00 || rdAddr > REG_COUNT) |-> !spiSoData)
        else $error("Unimplemented address not read as zero");
    AST_LATCH_READ: assert property (@(posedge spiClk) disable iff (!reset_n)
        latchKnown[1] && isRead && hdr[7:0] == 8'h01 &&
        bitCnt == 16'h001E |-> spiSoData == latchKnown[0])
        else $error("Latch bit read back wrong");
    AST_RESET_QUIET: assert property (@(posedge ref_clk)
        !reset_n |-> spiSoEnN && !spiSoData)
        else $error("Output active during reset");
endmodule : sra_link_monitor

bind sra_status_access sra_link_monitor #(.REG_COUNT(REG_COUNT)) i_mon (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .spiClk   (spiClk),
    .spiCsN   (spiCsN),
    .spiSi    (spiSi),
    .spiSoData(spiSoData),
    .spiSoEnN (spiSoEnN)
);
`default_nettype wire

// ### sra_host_model.sv
// Purpose : Host side of the serial link, mode 0
// Assumes : Link clock 15 ns, idle low and stopped between frames
// Notes   : Frame length is chosen by the caller, so aborts are possible
`timescale 1ns/10ps
`default_nettype none
module sra_host_model (
    input  wire logic ref_clk,
    output var  logic spiClk,
    output var  logic spiCsN,
    output var  logic spiSi,
    input  wire logic soWire
);
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiSi  = 1'b0;
    end

    task automatic frame(input logic [127:0] tx, input int nbits,
                         output logic [127:0] rx);
        rx = '0;
        @(negedge ref_clk);
        #3.3 spiCsN = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spiSi = tx[127 - i];
            #7.5 spiClk = 1'b1;
            rx = {rx[126:0], soWire};
            #7.5 spiClk = 1'b0;
        end
        #7.5 spiCsN = 1'b1;
        // Released line must not look held
        spiSi = ~spiSi;
        #500;
    endtask : frame
endmodule : sra_host_model
`default_nettype wire

// ### testbench.sv
// Purpose : Self-checking bench for the status register block
// Assumes : Host model drives the link, bench checks read data
// Notes   : Table rows, then continuous read, wrap, abort and reset
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sra_pkg::*;
    typedef struct {
        sra_byte_t   pre;
        logic [31:0] tx;
        int          nbits;
        sra_byte_t   addr;
        sra_byte_t   exp;
    } sra_row_t;
    logic         ref_clk;
    logic         reset_n;
    logic         spiClk;
    logic         spiCsN;
    logic         spiSi;
    logic         spiSoData;
    logic         spiSoEnN;
    wire          soWire;
    logic [127:0] rx;
    int           errCount;
    int           checksDone;
    // Write enables (8'h06) or volatile enables (8'h50) precede writes, except in the row with pre 8'h00
    sra_row_t rows [12] = '{
        '{8'h06, 32'h7102_A500, 24, 8'h02, 8'hA5},
        '{8'h06, 32'h7106_3C00, 24, 8'h06, 8'h3C},
        '{8'h50, 32'h315A_0000, 16, 8'h02, 8'h5A},
        '{8'h06, 32'h11C3_0000, 16, 8'h03, 8'hC3},
        '{8'h06, 32'h01F2_0000, 16, 8'h01, 8'hF0},
        '{8'h00, 32'h3111_0000, 16, 8'h02, 8'h5A},
        '{8'h06, 32'h0184_7E00, 24, 8'h02, 8'h7E},
        '{8'h06, 32'h7100_FF00, 24, 8'h01, 8'h84},
        '{8'h06, 32'h7107_FF00, 24, 8'h01, 8'h84},
        '{8'h06, 32'h7104_9977, 32, 8'h04, 8'h00},
        '{8'h50, 32'h7105_6600, 24, 8'h05, 8'h66},
        '{8'h06, 32'h3112_0000, 13, 8'h01, 8'h86}
    };
    assign soWire = spiSoEnN ? 1'bz : spiSoData;

    sra_status_access #(.REG_COUNT(6)) i_dut (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .spiClk   (spiClk),
        .spiCsN   (spiCsN),
        .spiSi    (spiSi),
        .spiSoData(spiSoData),
        .spiSoEnN (spiSoEnN)
    );
    sra_host_model i_host (
        .ref_clk(ref_clk),
        .spiClk (spiClk),
        .spiCsN (spiCsN),
        .spiSi  (spiSi),
        .soWire (soWire)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic rd(input sra_byte_t a, input int n);
        i_host.frame({8'h65, a, 8'h00, 104'h0}, 24 + 8 * n, rx);
    endtask : rd

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        #1_000_000;
        errCount++;
        complete_run();
    end

    initial begin
        errCount = 0;
        checksDone = 0;
        reset_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        foreach (rows[i]) begin
            if (rows[i].pre !== 8'h00) begin
                i_host.frame({rows[i].pre, 120'h0}, 8, rx);
            end
            i_host.frame({rows[i].tx, 96'h0}, rows[i].nbits, rx);
            rd(rows[i].addr, 1);
            chk(64'(rx[7:0]), 64'(rows[i].exp));
        end
        $display("Table test done");
        rd(8'h01, 7);
        chk(64'(rx[55:0]), 64'h0086_7EC3_0066_3C00);
        $display("Continuous read test done");
        rd(8'hFF, 3);
        chk(64'(rx[23:0]), 64'h0000_0000_0000_0086);
        $display("Wrap test done");
        i_host.frame({24'h6501_00, 104'h0}, 28, rx);
        chk(64'(rx[3:0]), 64'h0000_0000_0000_0008);
        chk(64'(spiSoEnN), 64'h0000_0000_0000_0001);
        $display("Early release test done");
        @(negedge ref_clk);
        reset_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd(8'h02, 1);
        chk(64'(rx[7:0]), 64'h0000_0000_0000_0000);
        i_host.frame({8'h06, 120'h0}, 8, rx);
        rd(8'h01, 1);
        chk(64'(rx[7:0]), 64'h0000_0000_0000_0002);
        $display("Reset test done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
